// ===== inc/acc_pkg.sv
// constants shared by the converter control block
package acc_pkg;

  // ==========================================================
  // register word indices (byte address = index * 4)
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_RESULT_HIGH_BYTE = 10'h01e;
  localparam logic [9:0] IDX_CONVERTER_CONTROL = 10'h01f;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08c;
  localparam logic [9:0] IDX_RESULT_LOW_BYTE = 10'h09e;
  localparam logic [9:0] IDX_CONVERTER_CONFIG = 10'h09f;
  localparam logic [9:0] IDX_PORT_READ = 10'h020;

  // ==========================================================
  // field positions
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_GO_DONE = 2;
  localparam int POS_CHANNEL = 3;
  localparam int POS_CLOCK_SELECT = 6;
  localparam int BIT_RESULT_FORMAT = 7;
  localparam int BIT_DONE_FLAG = 6;
  localparam int BIT_DONE_IRQ_ENABLE = 6;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
  localparam logic [3:0] RST_PORT_CONFIG = 4'h0;
  localparam logic RST_RESULT_FORMAT = 1'b0;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;

  // ==========================================================
  // clock select codes and timing
  localparam logic [1:0] CS_OSC_2 = 2'h0;
  localparam logic [1:0] CS_OSC_8 = 2'h1;
  localparam logic [1:0] CS_OSC_32 = 2'h2;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TOSC_NS = 100;
  localparam int TCY_NS = 4 * TOSC_NS;
  localparam int TCY_CYC = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAD_OSC_2 = 2 * TOSC_NS / CLK_PERIOD_NS;
  localparam int TAD_OSC_8 = 8 * TOSC_NS / CLK_PERIOD_NS;
  localparam int TAD_OSC_32 = 32 * TOSC_NS / CLK_PERIOD_NS;
  localparam int CONV_TAD = 12;
  localparam int HOLD_TAD = 2;
  localparam int RESULT_BITS = 10;

  typedef enum logic [1:0] {
    ST_ACQ   = 2'b00,
    ST_FIRST = 2'b01,
    ST_CONV  = 2'b10,
    ST_HOLD  = 2'b11
  } acc_state_e;

endpackage : acc_pkg

// ===== logic/acc_top.sv
// converter control: registers, clocking, sequencing and result
//
// What this block does
// - a conversion spans twelve bit periods
// - clock select picks 2, 8, 32 or RC
// - RC bit period comes from the RC tick
// - analog pins must be inputs, else drive converted
// - conversion ignores channel and direction settings
// - analog pins read zero on port read
// - clearing go aborts; result keeps old value
// - abort waits two periods, then reacquires
// - first segment spans one instruction cycle at least
// - completion loads justified result, zero padded
// - result bytes are plain storage when idle
// - RC start waits one instruction cycle
// - halt completion clears go, wakes if enabled
// - halt with non-RC clock aborts, powers down
// - reset clears control, all pins analog
// - reset never touches the result pair
// - done clears go, sets flag, gated request
// - two periods hold-off after every conversion
// - format selects right or left justification
`timescale 1ns/1ps
`default_nettype none

module acc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt,
  input  wire logic        rc_tick,
  input  wire logic [7:0]  port_pins,
  input  wire logic        ana_decision,
  output logic      [2:0]  ana_channel,
  output logic             ana_power,
  output logic             ana_sample,
  output logic             ana_start,
  output logic             ana_bit_strobe,
  output logic             irq_request,
  output logic             wake_request
);

  // ==========================================================
  // registers and state
  logic [1:0]  clock_select_field;
  logic [2:0]  channel_select_field;
  logic        go_done;
  logic        converter_on;
  logic        result_format;
  logic [3:0]  port_config;
  logic        convert_done_flag;
  logic        convert_done_irq_enable;
  logic [7:0]  interrupt_control;
  logic [7:0]  result_high_byte;
  logic [7:0]  result_low_byte;
  acc_pkg::acc_state_e state;
  logic [4:0]  tad_cnt;
  logic [2:0]  tcy_cnt;
  logic [3:0]  bit_idx;
  logic [9:0]  sar;
  logic [1:0]  rc_sync;
  logic        rc_prev;
  logic [7:0]  pin_sync1;
  logic [7:0]  pin_sync2;
  logic [1:0]  dec_sync;
  logic [7:0]  analog_mask;
  logic [4:0]  tad_limit;
  logic        tad_tick;
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic [9:0]  idx;
  logic [7:0]  wbyte;
  logic        wr_control;
  logic        sw_go_set;
  logic        sw_go_clear;
  logic        conv_busy;
  logic        halt_abort;
  logic        abort;
  logic        complete;
  logic [9:0]  next_result;
  logic [7:0]  rdata;

  // ==========================================================
  // input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync  <= 2'b00;
      rc_prev  <= 1'b0;
      dec_sync <= 2'b00;
    end else begin
      rc_sync  <= {rc_sync[0], rc_tick};
      rc_prev  <= rc_sync[1];
      dec_sync <= {dec_sync[0], ana_decision};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 8'h00;
      pin_sync2 <= 8'h00;
    end else begin
      pin_sync1 <= port_pins;
      pin_sync2 <= pin_sync1;
    end
  end

  // ==========================================================
  // analog pin map from port configuration
  always_comb begin
    case (port_config)
      4'h0, 4'h1, 4'h8: analog_mask = 8'hff;
      4'h2, 4'h3, 4'hc: analog_mask = 8'h1f;
      4'h4, 4'h5:       analog_mask = 8'h0b;
      4'h6, 4'h7:       analog_mask = 8'h00;
      4'h9, 4'ha, 4'hb: analog_mask = 8'h3f;
      4'hd:             analog_mask = 8'h0f;
      4'he:             analog_mask = 8'h01;
      4'hf:             analog_mask = 8'h0d;
      default:          analog_mask = 8'hff;
    endcase
  end

  // ==========================================================
  // bit period generator
  always_comb begin
    case (clock_select_field)
      acc_pkg::CS_OSC_2:  tad_limit = 5'(acc_pkg::TAD_OSC_2 - 1);
      acc_pkg::CS_OSC_8:  tad_limit = 5'(acc_pkg::TAD_OSC_8 - 1);
      acc_pkg::CS_OSC_32: tad_limit = 5'(acc_pkg::TAD_OSC_32 - 1);
      default:            tad_limit = 5'h00;
    endcase
  end

  // rc period is whatever the rc oscillator delivers, nominally 4 us
  assign tad_tick = (clock_select_field == acc_pkg::CS_RC) ?
                    (rc_sync[1] & ~rc_prev) :
                    (tad_cnt == tad_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tad_cnt <= 5'h00;
    end else if (sw_go_set || tad_tick || abort) begin
      tad_cnt <= 5'h00;
    end else begin
      tad_cnt <= tad_cnt + 5'h01;
    end
  end

  // ==========================================================
  // bus decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign idx = paddr[11:2];
  assign wbyte = pwdata[7:0];
  assign hit = (paddr[1:0] == 2'b00) &&
               (idx == acc_pkg::IDX_INTERRUPT_CONTROL ||
                idx == acc_pkg::IDX_PERIPHERAL_IRQ_FLAGS ||
                idx == acc_pkg::IDX_RESULT_HIGH_BYTE ||
                idx == acc_pkg::IDX_CONVERTER_CONTROL ||
                idx == acc_pkg::IDX_PERIPHERAL_IRQ_ENABLES ||
                idx == acc_pkg::IDX_RESULT_LOW_BYTE ||
                idx == acc_pkg::IDX_CONVERTER_CONFIG ||
                idx == acc_pkg::IDX_PORT_READ);
  assign wr_control = wr_en && hit &&
                      idx == acc_pkg::IDX_CONVERTER_CONTROL;

  // a start in the write that also enables is dropped
  assign sw_go_set = wr_control && wbyte[acc_pkg::BIT_GO_DONE] &&
                     converter_on && !go_done &&
                     state == acc_pkg::ST_ACQ;
  assign sw_go_clear = wr_control && !wbyte[acc_pkg::BIT_GO_DONE];
  assign conv_busy = state == acc_pkg::ST_FIRST ||
                     state == acc_pkg::ST_CONV;
  assign halt_abort = halt && conv_busy &&
                      clock_select_field != acc_pkg::CS_RC;
  assign abort = conv_busy && (sw_go_clear || halt_abort ||
                 (wr_control && !wbyte[acc_pkg::BIT_CONVERTER_ON]));
  assign complete = state == acc_pkg::ST_CONV && tad_tick &&
                    bit_idx == 4'(acc_pkg::RESULT_BITS) && !abort;

  always_comb begin
    case (idx)
      acc_pkg::IDX_INTERRUPT_CONTROL: rdata = interrupt_control;
      acc_pkg::IDX_PERIPHERAL_IRQ_FLAGS:
        rdata = 8'(convert_done_flag) << acc_pkg::BIT_DONE_FLAG;
      acc_pkg::IDX_RESULT_HIGH_BYTE: rdata = result_high_byte;
      acc_pkg::IDX_CONVERTER_CONTROL:
        rdata = {clock_select_field, channel_select_field,
                 go_done, 1'b0, converter_on};
      acc_pkg::IDX_PERIPHERAL_IRQ_ENABLES:
        rdata = 8'(convert_done_irq_enable) <<
                acc_pkg::BIT_DONE_IRQ_ENABLE;
      acc_pkg::IDX_RESULT_LOW_BYTE: rdata = result_low_byte;
      acc_pkg::IDX_CONVERTER_CONFIG:
        rdata = {result_format, 3'b000, port_config};
      acc_pkg::IDX_PORT_READ: rdata = pin_sync2 & ~analog_mask;
      default: rdata = 8'h00;
    endcase
  end

  // one wait-free answer: ready rises for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup && hit && !pwrite) ? {24'h00_0000, rdata}
                                           : 32'h0000_0000;
    end
  end

  // ==========================================================
  // control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_select_field   <= acc_pkg::RST_CONVERTER_CONTROL[7:6];
      channel_select_field <= acc_pkg::RST_CONVERTER_CONTROL[5:3];
      converter_on         <= acc_pkg::RST_CONVERTER_CONTROL[0];
      result_format        <= acc_pkg::RST_RESULT_FORMAT;
      port_config          <= acc_pkg::RST_PORT_CONFIG;
      interrupt_control    <= acc_pkg::RST_INTERRUPT_CONTROL;
      convert_done_irq_enable <= 1'b0;
    end else if (wr_en && hit) begin
      case (idx)
        acc_pkg::IDX_CONVERTER_CONTROL: begin
          clock_select_field   <= wbyte[7:6];
          channel_select_field <= wbyte[5:3];
          converter_on         <= wbyte[acc_pkg::BIT_CONVERTER_ON];
        end
        acc_pkg::IDX_CONVERTER_CONFIG: begin
          result_format <= wbyte[acc_pkg::BIT_RESULT_FORMAT];
          port_config   <= wbyte[3:0];
        end
        acc_pkg::IDX_INTERRUPT_CONTROL: interrupt_control <= wbyte;
        acc_pkg::IDX_PERIPHERAL_IRQ_ENABLES:
          convert_done_irq_enable <= wbyte[acc_pkg::BIT_DONE_IRQ_ENABLE];
        default: ;
      endcase
    end
  end

  // go/done: set by software, cleared by completion or abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_done <= 1'b0;
    end else if (complete || abort) begin
      go_done <= 1'b0;
    end else if (sw_go_set) begin
      go_done <= 1'b1;
    end
  end

  // done flag: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_done_flag <= 1'b0;
    end else if (complete) begin
      convert_done_flag <= 1'b1;
    end else if (wr_en && hit &&
                 idx == acc_pkg::IDX_PERIPHERAL_IRQ_FLAGS) begin
      convert_done_flag <= wbyte[acc_pkg::BIT_DONE_FLAG];
    end
  end

  // ==========================================================
  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= acc_pkg::ST_ACQ;
      tcy_cnt <= 3'h0;
      bit_idx <= 4'h0;
      sar     <= 10'h000;
    end else begin
      case (state)
        acc_pkg::ST_ACQ: begin
          tcy_cnt <= 3'h0;
          bit_idx <= 4'h0;
          if (sw_go_set) begin
            state <= acc_pkg::ST_FIRST;
          end
        end
        acc_pkg::ST_FIRST: begin
          if (tcy_cnt != 3'(acc_pkg::TCY_CYC)) begin
            tcy_cnt <= tcy_cnt + 3'h1;
          end
          if (abort) begin
            state   <= acc_pkg::ST_HOLD;
            bit_idx <= 4'h0;
          end else if (tad_tick &&
                       tcy_cnt == 3'(acc_pkg::TCY_CYC)) begin
            state <= acc_pkg::ST_CONV;
          end
        end
        acc_pkg::ST_CONV: begin
          if (abort) begin
            state   <= acc_pkg::ST_HOLD;
            bit_idx <= 4'h0;
          end else if (tad_tick) begin
            if (bit_idx != 4'h0) begin
              sar[4'(acc_pkg::RESULT_BITS) - bit_idx] <= dec_sync[1];
            end
            if (complete) begin
              state   <= acc_pkg::ST_HOLD;
              bit_idx <= 4'h0;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        acc_pkg::ST_HOLD: begin
          if (tad_tick) begin
            if (bit_idx == 4'(acc_pkg::HOLD_TAD - 1)) begin
              state <= acc_pkg::ST_ACQ;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        default: state <= acc_pkg::ST_ACQ;
      endcase
    end
  end

  // last decision joins the register in the cycle the result loads
  always_comb begin
    next_result    = sar;
    next_result[0] = dec_sync[1];
  end

  // ==========================================================
  // result pair: no reset, so resets never disturb it
  always_ff @(posedge pclk) begin
    if (complete) begin
      if (result_format) begin
        result_high_byte <= {6'b00_0000, next_result[9:8]};
        result_low_byte  <= next_result[7:0];
      end else begin
        result_high_byte <= next_result[9:2];
        result_low_byte  <= {next_result[1:0], 6'b00_0000};
      end
    end else if (wr_en && hit) begin
      if (idx == acc_pkg::IDX_RESULT_HIGH_BYTE) begin
        result_high_byte <= wbyte;
      end
      if (idx == acc_pkg::IDX_RESULT_LOW_BYTE) begin
        result_low_byte <= wbyte;
      end
    end
  end

  // ==========================================================
  // analog core strobes and requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_channel    <= 3'h0;
      ana_power      <= 1'b0;
      ana_sample     <= 1'b0;
      ana_start      <= 1'b0;
      ana_bit_strobe <= 1'b0;
      irq_request    <= 1'b0;
      wake_request   <= 1'b0;
    end else begin
      // channel passes through whatever the pin direction is
      ana_channel    <= channel_select_field;
      // halt without the rc clock powers the core down; enable stays
      ana_power      <= converter_on &&
                        !(halt && clock_select_field != acc_pkg::CS_RC);
      ana_sample     <= converter_on && state == acc_pkg::ST_ACQ;
      ana_start      <= state == acc_pkg::ST_FIRST && tad_tick &&
                        tcy_cnt == 3'(acc_pkg::TCY_CYC) && !abort;
      ana_bit_strobe <= state == acc_pkg::ST_CONV && tad_tick &&
                        bit_idx < 4'(acc_pkg::RESULT_BITS) && !abort;
      irq_request    <= convert_done_flag && convert_done_irq_enable &&
                        interrupt_control[acc_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
                        && interrupt_control[acc_pkg::BIT_GLOBAL_IRQ_ENABLE];
      wake_request   <= halt && complete && convert_done_irq_enable;
    end
  end

endmodule : acc_top

`default_nettype wire

// ===== test/acc_analog_model.sv
// behavioural model of the analog sample-and-hold and comparator core
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ana_power,
  input  wire logic       ana_start,
  input  wire logic       ana_bit_strobe,
  input  wire logic [9:0] level,
  output logic            ana_decision
);
  // ==========================================================
  // one decision per bit period, most significant bit first
  int idx;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx          <= 9;
      ana_decision <= 1'b0;
    end else if (!ana_power) begin
      // powered down: no valid level, so keep it moving
      ana_decision <= ~ana_decision;
    end else if (ana_bit_strobe) begin
      ana_decision <= level[ana_start ? 9 : idx];
      idx          <= (ana_start ? 9 : idx) - 1;
    end else if (ana_start) begin
      idx <= 9;
    end
  end
endmodule : acc_analog_model
`default_nettype wire

// ===== test/acc_top_checker.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halt,
  input wire logic        rc_tick,
  input wire logic [7:0]  port_pins,
  input wire logic        ana_decision,
  input wire logic [2:0]  ana_channel,
  input wire logic        ana_power,
  input wire logic        ana_sample,
  input wire logic        ana_start,
  input wire logic        ana_bit_strobe,
  input wire logic        irq_request,
  input wire logic        wake_request
);
  // ==========================================================
  // configuration seen on completed writes
  logic [1:0] cs_q;
  logic [2:0] en_q;
  logic [7:0] gap;
  logic       wr_hit;
  logic [9:0] widx;
  assign wr_hit = psel && penable && pready && pwrite;
  assign widx   = paddr[11:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 2'h0;
      en_q <= 3'h0;
    end else if (wr_hit) begin
      if (widx == acc_pkg::IDX_CONVERTER_CONTROL) cs_q <= pwdata[7:6];
      if (widx == acc_pkg::IDX_INTERRUPT_CONTROL) en_q[1:0] <= pwdata[7:6];
      if (widx == acc_pkg::IDX_PERIPHERAL_IRQ_ENABLES) en_q[2] <= pwdata[6];
    end
  end
  // saturating count of cycles since the last bit strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 8'hff;
    else if (ana_bit_strobe) gap <= 8'h00;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_start_hold: assert property (ana_start |-> !ana_sample)
    else $error("sampling during start");
  chk_strobe_single: assert property (ana_bit_strobe |=> !ana_bit_strobe)
    else $error("bit strobe too long");
  chk_tick_eight: assert property (ana_bit_strobe &&
    cs_q == acc_pkg::CS_OSC_8 |=> !ana_bit_strobe[*7])
    else $error("bit period short at code 01");
  chk_tick_thirtytwo: assert property (ana_bit_strobe &&
    cs_q == acc_pkg::CS_OSC_32 |-> gap >= 8'h1f)
    else $error("bit period short at code 10");
  chk_wake_halt: assert property (wake_request |->
    halt && en_q[2] ##1 !wake_request)
    else $error("bad wake request");
  chk_halt_power: assert property (halt && $past(halt) &&
    $past(cs_q) != acc_pkg::CS_RC |-> !ana_power)
    else $error("core powered in halt");
  chk_irq_enabled: assert property (irq_request |-> $past(&en_q))
    else $error("request without enables");
  cover property (ana_start);
  cover property (wake_request);
  cover property (pslverr);
  cover property (halt && !ana_power);
endmodule : acc_top_checker
bind acc_top acc_top_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .halt(halt), .rc_tick(rc_tick), .port_pins(port_pins),
  .ana_decision(ana_decision), .ana_channel(ana_channel),
  .ana_power(ana_power), .ana_sample(ana_sample), .ana_start(ana_start),
  .ana_bit_strobe(ana_bit_strobe), .irq_request(irq_request),
  .wake_request(wake_request));
`default_nettype wire

// ===== test/acc_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_bench;
  // ==========================================================
  // signals
  localparam logic [9:0] CTL = acc_pkg::IDX_CONVERTER_CONTROL;
  localparam logic [9:0] CFG = acc_pkg::IDX_CONVERTER_CONFIG;
  localparam logic [9:0] RHI = acc_pkg::IDX_RESULT_HIGH_BYTE;
  localparam logic [9:0] RLO = acc_pkg::IDX_RESULT_LOW_BYTE;
  localparam logic [9:0] FLG = acc_pkg::IDX_PERIPHERAL_IRQ_FLAGS;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, halt = 1'b0, rc_tick = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0]  port_pins = 8'h00, q, ctl;
  logic [9:0]  level = 10'h000;
  logic [15:0] rnd = 16'h004f, xr;
  logic [2:0]  ana_channel;
  logic pready, pslverr, ana_decision, ana_power, ana_sample, ana_start;
  logic ana_bit_strobe, irq_request, wake_request;
  int n_errors = 0, checked = 0, n, cyc;
  int bit_conversion_period[4] = '{acc_pkg::TAD_OSC_2, acc_pkg::TAD_OSC_8,
                 acc_pkg::TAD_OSC_32, 40};
  time t0;
  acc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt(halt),
    .rc_tick(rc_tick), .port_pins(port_pins), .ana_decision(ana_decision),
    .ana_channel(ana_channel), .ana_power(ana_power),
    .ana_sample(ana_sample), .ana_start(ana_start),
    .ana_bit_strobe(ana_bit_strobe), .irq_request(irq_request),
    .wake_request(wake_request));
  acc_analog_model u_core (.pclk(pclk), .presetn(presetn),
    .ana_power(ana_power), .ana_start(ana_start),
    .ana_bit_strobe(ana_bit_strobe), .level(level),
    .ana_decision(ana_decision));
  always #50 pclk = ~pclk;
  // rc oscillator: 4 us bit period, edges placed by the bench
  initial forever begin
    repeat (20) @(posedge pclk);
    rc_tick <= ~rc_tick;
  end
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] justify(input logic [9:0] v,
                                          input logic f);
    return f ? {6'h00, v} : {v, 6'h00};
  endfunction : justify
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(q, exp);
  endtask : rd
  task automatic wait_go();
    n = 0;
    do begin
      apb(1'b0, CTL, 8'h00);
      n++;
    end while (q[acc_pkg::BIT_GO_DONE] !== 1'b0 && n < 1000);
    check({7'h00, q[acc_pkg::BIT_GO_DONE]}, 8'h00);
  endtask : wait_go
  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 8'h00);
    rd(CFG, 8'h00);
    rd(FLG, 8'h00);
    apb(1'b0, 10'h3ff, 8'h00);
    check({7'h00, e}, 8'h01);
    apb(1'b1, RHI, 8'ha5);
    apb(1'b1, RLO, 8'h3c);
    rd(RHI, 8'ha5);
    rd(RLO, 8'h3c);
    apb(1'b1, CTL, 8'h05);
    rd(CTL, 8'h01);
    $display("test reset done");
    for (int cs = 0; cs < 4; cs++) begin
      rnd = lfsr(rnd);
      level <= rnd[9:0];
      ctl = {cs[1:0], rnd[13:11], 3'b001};
      xr = justify(rnd[9:0], rnd[10]);
      apb(1'b1, CFG, {rnd[10], 7'h00});
      apb(1'b1, CTL, ctl);
      t0 = $time;
      apb(1'b1, CTL, ctl | 8'h04);
      wait_go();
      cyc = int'(($time - t0) / 100);
      checked++;
      if (cyc < 11 * bit_conversion_period[cs] + acc_pkg::TCY_CYC) begin
        n_errors++;
        $display("[FAIL] %0t conversion too short %0d", $time, cyc);
      end
      // codes below a 1.6 us bit period give no valid result
      if (bit_conversion_period[cs] * acc_pkg::CLK_PERIOD_NS >= 1600) begin
        rd(RHI, xr[15:8]);
        rd(RLO, xr[7:0]);
      end
      rd(FLG, 8'h40);
      check({5'h00, ana_channel}, {5'h00, ctl[5:3]});
      apb(1'b1, FLG, 8'h00);
      repeat (120) @(posedge pclk);
    end
    $display("test conversions done");
    level <= ~level;
    apb(1'b1, CTL, 8'h85);
    repeat (40) @(posedge pclk);
    apb(1'b1, CTL, 8'h81);
    rd(CTL, 8'h81);
    repeat (10) @(posedge pclk);
    check({7'h00, ana_sample}, 8'h00);
    repeat (80) @(posedge pclk);
    check({7'h00, ana_sample}, 8'h01);
    rd(RHI, xr[15:8]);
    rd(RLO, xr[7:0]);
    $display("test abort done");
    apb(1'b1, 10'h00b, 8'hc0);
    apb(1'b1, 10'h08c, 8'h40);
    apb(1'b1, CFG, 8'h80);
    rnd = lfsr(rnd);
    level <= rnd[9:0];
    xr = justify(rnd[9:0], 1'b1);
    apb(1'b1, CTL, 8'hc1);
    apb(1'b1, CTL, 8'hc5);
    halt <= 1'b1;
    n = 0;
    while (wake_request !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check({7'h00, wake_request}, 8'h01);
    halt <= 1'b0;
    rd(RHI, xr[15:8]);
    rd(RLO, xr[7:0]);
    rd(CTL, 8'hc1);
    check({7'h00, irq_request}, 8'h01);
    apb(1'b1, FLG, 8'h00);
    repeat (2) @(posedge pclk);
    check({7'h00, irq_request}, 8'h00);
    $display("test halt rc done");
    apb(1'b1, 10'h08c, 8'h00);
    repeat (120) @(posedge pclk);
    apb(1'b1, CTL, 8'h81);
    apb(1'b1, CTL, 8'h85);
    repeat (30) @(posedge pclk);
    halt <= 1'b1;
    repeat (10) @(posedge pclk);
    check({7'h00, ana_power}, 8'h00);
    halt <= 1'b0;
    rd(CTL, 8'h81);
    rd(RHI, xr[15:8]);
    $display("test halt abort done");
    rnd = lfsr(rnd);
    port_pins <= rnd[7:0];
    apb(1'b1, CFG, 8'h00);
    repeat (4) @(posedge pclk);
    rd(10'h020, 8'h00);
    apb(1'b1, CFG, 8'h06);
    rd(10'h020, rnd[7:0]);
    repeat (120) @(posedge pclk);
    apb(1'b1, CTL, 8'h85);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 8'h00);
    rd(CFG, 8'h00);
    rd(RHI, xr[15:8]);
    rd(RLO, xr[7:0]);
    $display("test ports and reset done");
    end_of_test();
  end
endmodule : acc_top_bench
`default_nettype wire
